// >>> fic_consts.svh
// Offsets, field positions, widths and reset values of the fault clear block.
// Included by the design files by bare name; definitions only.
`ifndef FIC_CONSTS_SVH
`define FIC_CONSTS_SVH

// Register word addresses on the internal register bus
`define FIC_ADDR_W 7
`define FIC_DATA_W 16
`define FIC_ADDR_CLR1 7'h68
`define FIC_ADDR_CLR2 7'h69
`define FIC_ADDR_CLR3 7'h6a
`define FIC_ADDR_STATE1 7'h6b
`define FIC_ADDR_STATE2 7'h6c
`define FIC_ADDR_STATE3 7'h6d

// Flag widths per bank
`define FIC_BANK_W 11
`define FIC_BANK3_W 2

// Field positions, first clear and state pair
`define FIC_B1_OVERVOLT 10
`define FIC_B1_UNDERVOLT 9
`define FIC_B1_TEMP 8
`define FIC_B1_ACC_TIMEOUT 7
`define FIC_B1_RX_ABORT 6
`define FIC_B1_SHADOW_DED 5
`define FIC_B1_SHADOW_SED 4
`define FIC_B1_NVM_DED 3
`define FIC_B1_NVM_SED 2
`define FIC_B1_OSC_RANGE 1
`define FIC_B1_OSC_STUCK 0

// Field positions, second pair
`define FIC_B2_PIN_OVERVOLT 10
`define FIC_B2_ANA_UNDERVOLT 9
`define FIC_B2_BUS_FAIL 8
`define FIC_B2_WDOG 7
`define FIC_B2_SEAL 6
`define FIC_B2_FSM 5
`define FIC_B2_VCM 4
`define FIC_B2_OVERCUR 3
`define FIC_B2_DIG_OVERVOLT 2
`define FIC_B2_GAIN 1
`define FIC_B2_RX_PATH 0

// Field positions, third pair; bits above are reserved
`define FIC_B3_TX_COIL 1
`define FIC_B3_SELFTEST 0

// Reset values
`define FIC_BANK_RST 11'h000
`define FIC_BANK3_RST 2'h0
`define FIC_RDATA_RST 16'h0000

`endif

// >>> fic_pkg.sv
// Types shared by the fault clear block.
// Assumes fic_consts.svh is on the include path.
`include "fic_consts.svh"

package fic_pkg;

	typedef logic [`FIC_BANK_W-1:0] fic_flags_t;
	typedef logic [`FIC_BANK3_W-1:0] fic_flags3_t;
	typedef logic [`FIC_ADDR_W-1:0] fic_addr_t;
	typedef logic [`FIC_DATA_W-1:0] fic_data_t;

	// Kind of register an address selects
	typedef enum logic [2:0] {
		FIC_SEL_NONE,
		FIC_SEL_CLR1,
		FIC_SEL_CLR2,
		FIC_SEL_CLR3,
		FIC_SEL_ST1,
		FIC_SEL_ST2,
		FIC_SEL_ST3
	} fic_sel_t;

endpackage

// >>> fic_flag_bank.sv
// Bank of latched fault flags with a set input and a write-one clear input.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps

module fic_flag_bank #(
	parameter int W = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flags_q
);

	logic [W-1:0] flags_d;

	// Set wins over clear so an event in the clearing cycle survives
	// R12: set beats clear
	assign flags_d = (flags_q & ~clr_i) | set_i;

	// Flags hold until cleared
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_q <= '0;
		else
			flags_q <= flags_d;
	end

endmodule

// >>> fic_top.sv
// Fault interrupt clear logic: three write-one clear registers, the
// latched fault flags they act on, and the read-only state registers.
// Assumes fault events are one-cycle pulses on mclk and that the
// register master follows two-phase setup/access bus signalling.
//
// Function
// R1: Clear-1 bits 10..8 clear voltage/temperature flags
// R2: Clear-1 bits 7,6 clear serial access faults
// R3: Clear-1 bits 5..2 clear memory ECC flags
// R4: Clear-1 bits 1,0 clear oscillator faults
// R5: Clear-2 bits 10,9,2 clear supply/pin flags
// R6: Reject read-only writes, flag; clear-2 bit 8
// R7: Clear-2 bits 7..5 clear watchdog/seal/FSM flags
// R8: Clear-2 bits 4,3 clear output buffer faults
// R9: Clear-2 bits 1,0 clear gain/receiver faults
// R10: Clear-3 bits 1,0 used; 10..2 reserved
// R11: State flags read 1 when request pending
// R12: Detection wins over simultaneous clear write
`timescale 1ns/1ps
`include "fic_consts.svh"

module fic_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`FIC_ADDR_W-1:0] paddr,
	input wire logic [`FIC_DATA_W-1:0] pwdata,
	output logic [`FIC_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`FIC_BANK_W-1:0] fault_evt_one,
	input wire logic [`FIC_BANK_W-1:0] fault_evt_two,
	input wire logic [`FIC_BANK3_W-1:0] fault_evt_three,
	output logic [`FIC_BANK_W-1:0] fault_state_one,
	output logic [`FIC_BANK_W-1:0] fault_state_two,
	output logic [`FIC_BANK3_W-1:0] fault_state_three,
	output logic fault_pending
);

	// Address decode, used for both the setup and the access phase
	function automatic fic_pkg::fic_sel_t fic_decode(
		input fic_pkg::fic_addr_t a
	);
		fic_pkg::fic_sel_t s;
		s = fic_pkg::FIC_SEL_NONE;
		unique case (a)
			`FIC_ADDR_CLR1: s = fic_pkg::FIC_SEL_CLR1;
			`FIC_ADDR_CLR2: s = fic_pkg::FIC_SEL_CLR2;
			`FIC_ADDR_CLR3: s = fic_pkg::FIC_SEL_CLR3;
			`FIC_ADDR_STATE1: s = fic_pkg::FIC_SEL_ST1;
			`FIC_ADDR_STATE2: s = fic_pkg::FIC_SEL_ST2;
			`FIC_ADDR_STATE3: s = fic_pkg::FIC_SEL_ST3;
			default: s = fic_pkg::FIC_SEL_NONE;
		endcase
		return s;
	endfunction

	// Pad a flag bank to the data width; upper bits read as zero
	function automatic fic_pkg::fic_data_t fic_pad(
		input fic_pkg::fic_flags_t f
	);
		return {{(`FIC_DATA_W-`FIC_BANK_W){1'b0}}, f};
	endfunction

	logic rst_meta_q;
	logic rst_sync_q;
	fic_pkg::fic_sel_t sel;
	logic setup_ph;
	logic access_ph;
	logic wr_acc;
	logic sel_clr;
	logic sel_state;
	logic wr_ro;
	logic acc_err;
	fic_pkg::fic_flags_t wr_bits;
	fic_pkg::fic_flags_t clr_one;
	fic_pkg::fic_flags_t clr_two;
	fic_pkg::fic_flags3_t clr_three;
	fic_pkg::fic_flags_t set_two;
	fic_pkg::fic_flags_t st_one;
	fic_pkg::fic_flags_t st_two;
	fic_pkg::fic_flags3_t st_three;
	fic_pkg::fic_data_t rdata_d;
	logic [`FIC_DATA_W-1:0] rdata_q;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Bus phases and address class
	assign sel = fic_decode(paddr);
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_acc = access_ph & pwrite;
	assign sel_clr = (sel == fic_pkg::FIC_SEL_CLR1) |
		(sel == fic_pkg::FIC_SEL_CLR2) |
		(sel == fic_pkg::FIC_SEL_CLR3);
	assign sel_state = (sel == fic_pkg::FIC_SEL_ST1) |
		(sel == fic_pkg::FIC_SEL_ST2) |
		(sel == fic_pkg::FIC_SEL_ST3);

	// Zero bits of a write leave flags alone, so only ones pass
	assign wr_bits = pwdata[`FIC_BANK_W-1:0];

	// R1: voltage, temperature clear
	// R2: serial fault clear
	// R3: ECC flag clear
	// R4: oscillator flag clear
	assign clr_one = (wr_acc && sel == fic_pkg::FIC_SEL_CLR1) ?
		wr_bits : `FIC_BANK_RST;

	// R5: supply flag clear
	// R7: watchdog, seal, FSM clear
	// R8: output buffer clear
	// R9: gain, receiver clear
	assign clr_two = (wr_acc && sel == fic_pkg::FIC_SEL_CLR2) ?
		wr_bits : `FIC_BANK_RST;

	// R10: reserved bits dropped
	assign clr_three = (wr_acc && sel == fic_pkg::FIC_SEL_CLR3) ?
		wr_bits[`FIC_B3_TX_COIL:`FIC_B3_SELFTEST] : `FIC_BANK3_RST;

	// A write to a state register ignores its data and is reported.
	// R6: reject read-only write
	assign wr_ro = wr_acc & sel_state;

	// R6: flag rejected write
	assign set_two = fault_evt_two |
		({{(`FIC_BANK_W-1){1'b0}}, wr_ro} << `FIC_B2_BUS_FAIL);

	// Unmapped addresses and rejected writes answer with an error
	assign acc_err = access_ph & (wr_ro | ~(sel_clr | sel_state));

	// Flag banks; the third bank only carries its two live bits
	// R12: detection keeps flag
	fic_flag_bank #(
		.W(`FIC_BANK_W)
	) u_bank_one (
		.clk(mclk),
		.rst_n(rst_sync_q),
		.set_i(fault_evt_one),
		.clr_i(clr_one),
		.flags_q(st_one)
	);

	fic_flag_bank #(
		.W(`FIC_BANK_W)
	) u_bank_two (
		.clk(mclk),
		.rst_n(rst_sync_q),
		.set_i(set_two),
		.clr_i(clr_two),
		.flags_q(st_two)
	);

	fic_flag_bank #(
		.W(`FIC_BANK3_W)
	) u_bank_three (
		.clk(mclk),
		.rst_n(rst_sync_q),
		.set_i(fault_evt_three),
		.clr_i(clr_three),
		.flags_q(st_three)
	);

	// Read data; clear registers are write-only and read as zero
	// R11: state readback
	always_comb
	begin
		rdata_d = `FIC_RDATA_RST;
		unique case (sel)
			fic_pkg::FIC_SEL_ST1: rdata_d = fic_pad(st_one);
			fic_pkg::FIC_SEL_ST2: rdata_d = fic_pad(st_two);
			fic_pkg::FIC_SEL_ST3: rdata_d = fic_pad(
				{{(`FIC_BANK_W-`FIC_BANK3_W){1'b0}}, st_three});
			default: rdata_d = `FIC_RDATA_RST;
		endcase
	end

	// Read data is captured in the setup phase so it is from a flop
	// while the access phase runs with no wait state.
	always_ff @(posedge mclk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rdata_q <= `FIC_RDATA_RST;
		else if (setup_ph && !pwrite)
			rdata_q <= rdata_d;
	end

	// Every access completes in one access cycle
	assign pready = 1'b1;
	assign pslverr = acc_err;
	assign prdata = rdata_q;

	// Latched flags straight from the bank flops
	assign fault_state_one = st_one;
	assign fault_state_two = st_two;
	assign fault_state_three = st_three;
	assign fault_pending = (|st_one) | (|st_two) | (|st_three);

endmodule

// >>> fic_top_properties.sv
// Checker for the fault clear block: clears, events, refusals, reads.
// Bound into fic_top; sees its ports only, one clock.
`timescale 1ns/1ps
module fic_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [6:0] paddr,
	input wire logic [15:0] pwdata,
	input wire logic [15:0] prdata,
	input wire logic pslverr,
	input wire logic [10:0] fault_evt_one,
	input wire logic [10:0] fault_evt_two,
	input wire logic [1:0] fault_evt_three,
	input wire logic [10:0] fault_state_one,
	input wire logic [10:0] fault_state_two,
	input wire logic [1:0] fault_state_three,
	input wire logic fault_pending
);
	// Write access cycle; events are excluded so set-wins stays apart
	wire wr = psel & penable & pwrite;
	logic rst_meta_q;
	logic rst_ok_q;

	// Local copy of the design's two-flop reset release, so checks wake
	// up with the flag banks and not two edges early
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_ok_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_ok_q <= rst_meta_q;
		end
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_ok_q);
	clr_one_a:
	assert property (wr && paddr == 7'h68 && !fault_evt_one |=>
		fault_state_one == ($past(fault_state_one) & ~$past(pwdata[10:0])))
		else $error("clear one wrong");
	clr_two_a:
	assert property (wr && paddr == 7'h69 && !fault_evt_two |=>
		fault_state_two == ($past(fault_state_two) & ~$past(pwdata[10:0])))
		else $error("clear two wrong");
	clr_three_a:
	assert property (wr && paddr == 7'h6a && !fault_evt_three |=>
		fault_state_three ==
		($past(fault_state_three) & ~$past(pwdata[1:0])))
		else $error("clear three wrong");
	evt_wins_a:
	assert property (|fault_evt_one |=> (fault_state_one &
		$past(fault_evt_one)) == $past(fault_evt_one))
		else $error("event lost");
	ro_reject_a:
	assert property (wr && paddr inside {[7'h6b:7'h6d]} |->
		pslverr ##1 fault_state_two[8]) else $error("write not refused");
	clr_no_err_a:
	assert property (wr && paddr inside {[7'h68:7'h6a]} |-> !pslverr)
		else $error("clear write refused");
	pend_or_a:
	assert property (fault_pending == |{fault_state_one,
		fault_state_two, fault_state_three}) else $error("pending wrong");
	state_read_a:
	assert property (psel && !penable && !pwrite && paddr == 7'h6b ##1
		penable |-> prdata == $past(fault_state_one))
		else $error("state read wrong");
endmodule
bind fic_top fic_checker u_fic_checker (.*);

// >>> fic_master.sv
// Register master model: setup then access, held until ready.
// Assumes the bench calls acc from one process at a time.
`timescale 1ns/1ps
module fic_master (
	input wire logic mclk,
	input wire logic pready,
	input wire logic [15:0] prdata,
	input wire logic pslverr,
	output logic psel = 1'h0,
	output logic penable = 1'h0,
	output logic pwrite = 1'h0,
	output logic [6:0] paddr = 7'h00,
	output logic [15:0] pwdata = 16'h0000
);
	// Accesses that never saw ready; the bench counts them as mismatches
	int timeouts = 0;
	// Answer taken at the edge ready is seen; bounded wait
	task automatic acc(input logic w, input logic [6:0] a,
		input logic [15:0] d, output logic [15:0] r, output logic e);
		int n;
		n = 0;
		@(posedge mclk);
		#1;
		psel = 1'h1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(posedge mclk);
		#1;
		penable = 1'h1;
		@(posedge mclk);
		while (!pready && n < 8)
		begin
			n++;
			@(posedge mclk);
		end
		if (!pready)
			timeouts++;
		r = prdata;
		e = pslverr;
		#1;
		psel = 1'h0;
		penable = 1'h0;
		// Released lines show no stale value
		paddr = ~paddr;
		pwdata = ~pwdata;
	endtask
endmodule

// >>> fic_top_tb.sv
// Bench for the fault clear block: events, clears, refusals, reads.
// Assumes the master model drives the bus and the bench the events.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module fic_top_tb;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, fault_pending, e;
	logic [6:0] paddr;
	logic [15:0] pwdata, prdata, r;
	logic [10:0] fault_evt_one = 11'h000;
	logic [10:0] fault_evt_two = 11'h000;
	logic [1:0] fault_evt_three = 2'h0;
	logic [10:0] fault_state_one, fault_state_two, f, x;
	logic [1:0] fault_state_three;
	int mismatches = 0;
	int tests_run = 0;
	fic_top u_fic_top (.*);
	fic_master u_fic_master (.*);
	always #12.5 mclk = ~mclk;
	function automatic logic [10:0] st(input int b);
		return b == 0 ? fault_state_one : b == 1 ? fault_state_two :
			{9'h000, fault_state_three};
	endfunction
	task automatic summarize();
		mismatches += u_fic_master.timeouts;
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		summarize();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(posedge mclk);
		#1;
		rst_n = 1'h1;
		repeat (3) @(posedge mclk);
		#1;
		`CHK(fault_pending, 1'h0)
		{fault_evt_one, fault_evt_two, fault_evt_three} = '1;
		@(posedge mclk);
		#1;
		{fault_evt_one, fault_evt_two, fault_evt_three} = '0;
		`CHK(fault_pending, 1'h1)
		for (int b = 0; b < 3; b++)
		begin
			f = b == 2 ? 11'h003 : 11'h7ff;
			x = f & 11'h2aa;
			`CHK(st(b), f)
			u_fic_master.acc(1'h1, 7'h68 + 7'(b), 16'h0000, r, e);
			`CHK(st(b), f)
			`CHK(pready, 1'h1)
			u_fic_master.acc(1'h1, 7'h68 + 7'(b), 16'hf555, r, e);
			`CHK(st(b), x)
			`CHK(e, 1'h0)
			u_fic_master.acc(1'h0, 7'h6b + 7'(b), 16'h0000, r, e);
			`CHK(r, {5'h00, x})
			// Clear registers are write-only and read back as zero
			u_fic_master.acc(1'h0, 7'h68 + 7'(b), 16'h0000, r, e);
			`CHK({e, r}, 17'h00000)
			u_fic_master.acc(1'h1, 7'h68 + 7'(b), 16'h02aa, r, e);
			`CHK(st(b), 11'h000)
		end
		// Read-only write refused and flagged, then cleared
		u_fic_master.acc(1'h1, 7'h6c, 16'h07ff, r, e);
		`CHK(e, 1'h1)
		`CHK(fault_state_two, 11'h100)
		u_fic_master.acc(1'h1, 7'h69, 16'h0100, r, e);
		`CHK(fault_state_two, 11'h000)
		u_fic_master.acc(1'h1, 7'h70, 16'h07ff, r, e);
		`CHK({e, fault_state_two}, 12'h800)
		u_fic_master.acc(1'h0, 7'h70, 16'h0000, r, e);
		`CHK({e, r}, 17'h10000)
		// Event lands on the clearing edge: the flag must survive
		fork
			u_fic_master.acc(1'h1, 7'h68, 16'h0001, r, e);
			begin
				repeat (2) @(posedge mclk);
				#1;
				fault_evt_one = 11'h001;
				@(posedge mclk);
				#1;
				fault_evt_one = 11'h000;
			end
		join
		`CHK(fault_state_one, 11'h001)
		u_fic_master.acc(1'h1, 7'h68, 16'h0001, r, e);
		`CHK(fault_pending, 1'h0)
		summarize();
	end
endmodule
